// ==== rtl/srf_pkg.sv ====
// Types shared by the refresh block.
package srf_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_REFRESH = 2'b01,
        ST_SELF = 2'b10,
        ST_EXIT = 2'b11
    } srf_state_t;
endpackage

// ==== rtl/srf_refresh_ctrl.sv ====
// Refresh, self-refresh and write-burst control of the memory device, with an APB register file.
//
// Local design decisions: the register addresses and the APB interface to the registers.
`include "srf_regs.svh"
// Operation
// - Refresh decoded with clock enable high.
// - Internal counter addresses rows; banks left idle.
// - Self-refresh entry decoded with clock enable low.
// - In self-refresh only clock enable matters; the code also needs a NOP or deselect with clock enable high to exit.
// - Loop off on entry, reset on exit.
// - Internal refresh within clock-enable pulse time.
// - Exit on clock enable rise; wait unlocked delay.
// - Mode bits choose chop, eight, or on-the-fly.
// - Chop select bit picks four or eight beats.
module srf_refresh_ctrl (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic chip_select_n,
    input wire logic row_strobe_n,
    input wire logic column_strobe_n,
    input wire logic write_enable_n,
    input wire logic clk_en_input,
    input wire logic burst_chop_select_bit,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic refresh_active,
    output logic self_refresh_active,
    output logic dll_enabled,
    output logic dll_reset,
    output logic [15:0] refresh_row,
    output logic burst_eight,
    output logic wr_first_beat
);
    import srf_pkg::*;

    srf_state_t state_q;
    srf_state_t state_d;
    logic [7:0] xs_q;
    logic [7:0] xs_d;
    logic [31:0] cfg_q;
    logic [31:0] cfg_d;
    logic [31:0] lat_q;
    logic [31:0] lat_d;
    logic [31:0] prdata_d;
    logic pready_d;
    logic pslverr_d;
    logic sr_act_q;
    logic dll_on_q;
    logic dll_on_d;
    logic dll_rst_q;
    logic dll_rst_d;
    logic bl8_q;
    logic bl8_d;
    logic [4:0] wl_q;
    logic [4:0] wl_d;
    logic wl_run_q;
    logic wl_run_d;
    logic beat_q;
    logic beat_d;
    logic ref_busy;
    logic ref_done;
    logic [15:0] ref_row;
    logic cmd_ref;
    logic cmd_wr;
    logic cmd_nop;
    logic ref_start;

    // Burst length chosen by the mode bits and, on the fly, by the chop select bit.
    function automatic logic burst_is_eight(input logic [1:0] mode, input logic chop_bit);
        unique case (mode)
            `SRF_BL_FIXED8: burst_is_eight = 1'b1;
            `SRF_BL_OTF: burst_is_eight = chop_bit;
            `SRF_BL_CHOP4: burst_is_eight = 1'b0;
            default: burst_is_eight = 1'b1;
        endcase
    endfunction

    // Command decode from the strobes; refresh and entry share a code and differ by clock enable.
    assign cmd_ref = !chip_select_n && !row_strobe_n && !column_strobe_n && write_enable_n;
    assign cmd_wr = !chip_select_n && row_strobe_n && !column_strobe_n && !write_enable_n;
    assign cmd_nop = chip_select_n || (row_strobe_n && column_strobe_n && write_enable_n);
    assign ref_start = (state_q == ST_IDLE) && clk_en_input && cmd_ref;

    srf_refresh_engine u_engine (
        .core_clk(core_clk),
        .srst(srst),
        .start(ref_start),
        .self_mode(state_q == ST_SELF),
        .busy_q(ref_busy),
        .done_q(ref_done),
        .row_q(ref_row)
    );

    // Main state machine for refresh, self-refresh residency and the exit delay.
    always_comb begin
        state_d = state_q;
        xs_d = xs_q;
        dll_on_d = dll_on_q;
        dll_rst_d = 1'b0;
        unique case (state_q)
            ST_IDLE: begin
                if (ref_start) begin
                    state_d = ST_REFRESH;
                end else if (!clk_en_input && cmd_ref) begin
                    state_d = ST_SELF;
                    dll_on_d = 1'b0;
                end
            end
            ST_REFRESH: begin
                if (ref_done) begin
                    state_d = ST_IDLE;
                end
            end
            ST_SELF: begin
                if (clk_en_input && cmd_nop) begin
                    state_d = ST_EXIT;
                    xs_d = 8'(`SRF_XS_CYC - 1);
                    dll_on_d = !cfg_q[`SRF_CFG_DLL_OFF_BIT];
                    dll_rst_d = !cfg_q[`SRF_CFG_DLL_OFF_BIT];
                end
            end
            ST_EXIT: begin
                if (xs_q == 8'h00) begin
                    state_d = ST_IDLE;
                end else begin
                    xs_d = xs_q - 8'h01;
                end
            end
        endcase
        if (state_q == ST_IDLE && state_d == ST_IDLE) begin
            dll_on_d = !cfg_q[`SRF_CFG_DLL_OFF_BIT];
        end
    end

    // Write path: burst length latch and the write latency countdown.
    always_comb begin
        bl8_d = bl8_q;
        wl_d = wl_q;
        wl_run_d = wl_run_q;
        beat_d = 1'b0;
        if (state_q == ST_IDLE && clk_en_input && cmd_wr) begin
            bl8_d = burst_is_eight(cfg_q[`SRF_CFG_BL_LSB +: 2], burst_chop_select_bit);
            wl_d = 5'(lat_q[`SRF_LAT_AL_LSB +: 4]) + 5'(lat_q[`SRF_LAT_CWL_LSB +: 4]) - 5'h01;
            wl_run_d = 1'b1;
        end else if (wl_run_q) begin
            if (wl_q == 5'h00) begin
                wl_run_d = 1'b0;
                beat_d = 1'b1;
            end else begin
                wl_d = wl_q - 5'h01;
            end
        end
    end

    // APB slave: one wait state, answer and data registered, unmapped addresses flag an error.
    always_comb begin
        cfg_d = cfg_q;
        lat_d = lat_q;
        prdata_d = prdata;
        pready_d = psel && penable && !pready;
        pslverr_d = 1'b0;
        if (pready_d) begin
            prdata_d = 32'h0000_0000;
            unique case (paddr)
                `SRF_CFG_OFS: prdata_d = cfg_q;
                `SRF_LAT_OFS: prdata_d = lat_q;
                `SRF_STAT_OFS: prdata_d = {ref_row, 12'h000, bl8_q, dll_on_q, 2'(state_q)};
                default: pslverr_d = 1'b1;
            endcase
            if (pwrite) begin
                pslverr_d = pslverr_d || (paddr == `SRF_STAT_OFS);
            end
        end
        // A write lands only at the edge where the master samples pready high.
        if (psel && penable && pready && pwrite) begin
            if (paddr == `SRF_CFG_OFS) begin
                cfg_d = {29'h0, pwdata[2:0]};
            end
            if (paddr == `SRF_LAT_OFS) begin
                lat_d = {24'h0, pwdata[7:0]};
            end
        end
    end

    // All registers of the block except wl_age_q, which the checks below keep.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_q <= ST_IDLE;
            xs_q <= 8'h00;
            cfg_q <= `SRF_CFG_RESET;
            lat_q <= `SRF_LAT_RESET;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            sr_act_q <= 1'b0;
            dll_on_q <= 1'b1;
            dll_rst_q <= 1'b0;
            bl8_q <= 1'b1;
            wl_q <= 5'h00;
            wl_run_q <= 1'b0;
            beat_q <= 1'b0;
        end else begin
            state_q <= state_d;
            xs_q <= xs_d;
            cfg_q <= cfg_d;
            lat_q <= lat_d;
            prdata <= prdata_d;
            pready <= pready_d;
            pslverr <= pslverr_d;
            sr_act_q <= (state_d == ST_SELF);
            dll_on_q <= dll_on_d;
            dll_rst_q <= dll_rst_d;
            bl8_q <= bl8_d;
            wl_q <= wl_d;
            wl_run_q <= wl_run_d;
            beat_q <= beat_d;
        end
    end

    assign refresh_active = ref_busy;
    assign self_refresh_active = sr_act_q;
    assign dll_enabled = dll_on_q;
    assign dll_reset = dll_rst_q;
    assign refresh_row = ref_row;
    assign burst_eight = bl8_q;
    assign wr_first_beat = beat_q;

    // Checks on the block's own behaviour.
    localparam int TCKE_LIM = `SRF_TCKE_CYC;
    localparam int XS_LIM = `SRF_XS_CYC;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence sr_enter_s;
        state_q == ST_IDLE && !clk_en_input && cmd_ref;
    endsequence
    sequence sr_exit_s;
        state_q == ST_SELF && clk_en_input && cmd_nop;
    endsequence

    ref_decode_a: assert property (ref_start |=> state_q == ST_REFRESH && ref_busy)
        else $error("refresh command not decoded");
    ref_idle_a: assert property (state_q == ST_REFRESH && ref_done |=> state_q == ST_IDLE
        && ref_row == $past(ref_row)) else $error("refresh did not end idle");
    sr_entry_a: assert property (sr_enter_s |=> state_q == ST_SELF ##1 sr_act_q)
        else $error("self-refresh entry not taken");
    sr_hold_a: assert property (state_q == ST_SELF && !clk_en_input |=> state_q == ST_SELF)
        else $error("self-refresh left with clock enable low");
    dll_off_a: assert property (sr_enter_s |=> !dll_on_q)
        else $error("loop still on in self-refresh");
    dll_back_a: assert property ((sr_exit_s and !cfg_q[`SRF_CFG_DLL_OFF_BIT])
        |=> dll_on_q && dll_reset) else $error("loop not reset on exit");
    dll_stay_a: assert property ((sr_exit_s and cfg_q[`SRF_CFG_DLL_OFF_BIT])
        |=> !dll_on_q && !dll_reset) else $error("loop woke while disabled");
    sr_first_ref_a: assert property (sr_enter_s |=> ##[1:TCKE_LIM] ref_busy)
        else $error("no internal refresh after entry");
    sr_exit_a: assert property (sr_exit_s |=> (state_q == ST_EXIT)[*3] ##[1:XS_LIM] state_q == ST_IDLE)
        else $error("exit delay wrong");
    burst_mode_a: assert property (state_q == ST_IDLE && clk_en_input && cmd_wr
        && cfg_q[1:0] == `SRF_BL_CHOP4 |=> !burst_eight) else $error("chop mode ignored");
    burst_otf_a: assert property (state_q == ST_IDLE && clk_en_input && cmd_wr
        && cfg_q[1:0] == `SRF_BL_OTF |=> burst_eight == $past(burst_chop_select_bit))
        else $error("on-the-fly burst length wrong");

    logic [5:0] wl_age_q;
    always_ff @(posedge core_clk) begin
        if (srst || (state_q == ST_IDLE && clk_en_input && cmd_wr)) begin
            wl_age_q <= 6'h00;
        end else if (wl_age_q != 6'h3F) begin
            wl_age_q <= wl_age_q + 6'h01;
        end
    end
    wr_latency_a: assert property (wr_first_beat |-> wl_age_q == 6'(lat_q[3:0]) + 6'(lat_q[7:4]))
        else $error("first write beat off latency");
endmodule // srf_refresh_ctrl

// ==== rtl/srf_refresh_engine.sv ====
// Refresh engine: internal row counter, refresh cycle timer and self-refresh interval timer.
`include "srf_regs.svh"
module srf_refresh_engine (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic start,
    input wire logic self_mode,
    output logic busy_q,
    output logic done_q,
    output logic [15:0] row_q
);
    import srf_pkg::*;

    logic busy_d;
    logic done_d;
    logic [15:0] row_d;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic [9:0] timer_q;
    logic [9:0] timer_d;
    logic tick;

    // The built-in timer fires at once on entry and then every average refresh interval.
    always_comb begin
        tick = self_mode && (timer_q == 10'h000);
        timer_d = timer_q;
        if (!self_mode) begin
            timer_d = 10'h000;
        end else if (tick) begin
            timer_d = 10'(`SRF_TREFI_CYC - 1);
        end else begin
            timer_d = timer_q - 10'h001;
        end
    end

    // A refresh runs for the refresh cycle time; the row comes from the counter only.
    always_comb begin
        busy_d = busy_q;
        done_d = 1'b0;
        cnt_d = cnt_q;
        row_d = row_q;
        if (busy_q) begin
            if (cnt_q == 8'h00) begin
                busy_d = 1'b0;
                done_d = 1'b1;
                row_d = row_q + 16'h0001;
            end else begin
                cnt_d = cnt_q - 8'h01;
            end
        end else if (start || tick) begin
            busy_d = 1'b1;
            cnt_d = 8'(`SRF_RFC_CYC - 1);
        end
    end

    // Registers of the engine.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            row_q <= 16'h0000;
            cnt_q <= 8'h00;
            timer_q <= 10'h000;
        end else begin
            busy_q <= busy_d;
            done_q <= done_d;
            row_q <= row_d;
            cnt_q <= cnt_d;
            timer_q <= timer_d;
        end
    end
endmodule // srf_refresh_engine

// ==== rtl/srf_regs.svh ====
// Register offsets, field positions, reset values and timing counts of the refresh block.
`ifndef SRF_REGS_SVH
`define SRF_REGS_SVH

// Register byte offsets on the APB bus.
`define SRF_CFG_OFS 8'h00
`define SRF_LAT_OFS 8'h04
`define SRF_STAT_OFS 8'h08

// Configuration fields: burst mode of mode_register_zero and the loop-off bit of mode_register_one.
`define SRF_CFG_BL_LSB 0
`define SRF_CFG_DLL_OFF_BIT 2
`define SRF_CFG_RESET 32'h0000_0000
// Latency fields: additive_latency and column_write_latency.
`define SRF_LAT_AL_LSB 0
`define SRF_LAT_CWL_LSB 4
`define SRF_LAT_RESET 32'h0000_0005

// Burst mode encodings.
`define SRF_BL_FIXED8 2'h0
`define SRF_BL_OTF 2'h1
`define SRF_BL_CHOP4 2'h2

// Timing figures in ns and derived cycle counts at the core clock.
`define SRF_CLK_NS 8
`define SRF_RFC_NS 160
`define SRF_XS_NS 170
`define SRF_TCKE_NS 5
`define SRF_TREFI_NS 7800
`define SRF_RFC_CYC ((`SRF_RFC_NS + `SRF_CLK_NS - 1) / `SRF_CLK_NS)
`define SRF_XS_CYC ((`SRF_XS_NS + `SRF_CLK_NS - 1) / `SRF_CLK_NS)
`define SRF_TCKE_CYC ((`SRF_TCKE_NS / `SRF_CLK_NS) < 1 ? 1 : (`SRF_TCKE_NS / `SRF_CLK_NS))
`define SRF_TREFI_CYC (`SRF_TREFI_NS / `SRF_CLK_NS)

`endif

// ==== sim/srf_ctrl_model.sv ====
// Memory controller model that drives the command pins of the refresh block.
`include "srf_regs.svh"
module srf_ctrl_model (
    input wire logic core_clk,
    output logic chip_select_n,
    output logic row_strobe_n,
    output logic column_strobe_n,
    output logic write_enable_n,
    output logic clk_en_input,
    output logic burst_chop_select_bit
);
    timeunit 1ns;
    timeprecision 1ns;
    int cyc = 0;
    int ready_at = 0;
    int write_at = 0;
    int ref_count = 0;
    // Counts clock edges so that the spacing after each command can be kept.
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
    end
    // The bus starts deselected with clock enable high. The model has no termination pin and
    // issues no read or precharge, so termination is always off and those spacings never arise.
    initial begin
        {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} = 4'hF;
        write_at = 0;
        clk_en_input = 1'b1;
        burst_chop_select_bit = 1'b0;
    end
    // Presents one command for one edge once the last spacing has run out, then NOP.
    task automatic send(input logic [3:0] cmd, input logic cke, input logic bc, input int gap);
        @(posedge core_clk);
        while (cyc < ready_at) begin
            @(posedge core_clk);
        end
        while (cmd == 4'h4 && cke && cyc < write_at) begin
            @(posedge core_clk);
        end
        // Refreshes are only pulled in, never postponed, and held back once eight are ahead.
        while (cmd == 4'h1 && cke && ref_count - cyc / `SRF_TREFI_CYC >= 8) begin
            @(posedge core_clk);
        end
        ref_count += int'(cmd == 4'h1 && cke);
        if (cmd == 4'h7 && cke && !clk_en_input) begin
            write_at = cyc + 513;
        end
        {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} <= cmd;
        clk_en_input <= cke;
        burst_chop_select_bit <= bc;
        ready_at = cyc + gap;
        @(posedge core_clk);
        {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} <= 4'h7;
        burst_chop_select_bit <= ~bc;
    endtask
endmodule // srf_ctrl_model

// ==== sim/srf_refresh_ctrl_bench.sv ====
// Self-checking bench for the refresh, self-refresh and write-burst block.
`include "srf_regs.svh"
module sdram_refresh_selfrefresh_write_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk, srst, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic refresh_active, self_refresh_active, dll_enabled, dll_reset, burst_eight;
    logic wr_first_beat, cs_n, ras_n, cas_n, we_n, cke, bc, err;
    logic [15:0] refresh_row, exp_row;
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;
    // The block under test with its command pins driven by the controller model.
    srf_refresh_ctrl dut (.core_clk(core_clk), .srst(srst), .chip_select_n(cs_n),
        .row_strobe_n(ras_n), .column_strobe_n(cas_n), .write_enable_n(we_n),
        .clk_en_input(cke), .burst_chop_select_bit(bc), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .refresh_active(refresh_active),
        .self_refresh_active(self_refresh_active), .dll_enabled(dll_enabled),
        .dll_reset(dll_reset), .refresh_row(refresh_row), .burst_eight(burst_eight),
        .wr_first_beat(wr_first_beat));
    srf_ctrl_model ctl (.core_clk(core_clk), .chip_select_n(cs_n), .row_strobe_n(ras_n),
        .column_strobe_n(cas_n), .write_enable_n(we_n), .clk_en_input(cke),
        .burst_chop_select_bit(bc));
    // Free-running 125 MHz clock.
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // Cuts a hang short well after the tests should have ended.
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            print_verdict();
        end
    end
    // Compares one value and reports a mismatch at once.
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // Waits n edges and samples after the updates of the last one have landed.
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // One APB transfer: setup, access held until pready is sampled high.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Reset levels, register reset values and refused accesses.
    task automatic t_reset();
        chk("dll_enabled", 1, dll_enabled);
        chk("burst_eight", 1, burst_eight);
        apb(1'b0, `SRF_CFG_OFS, 0);
        chk("cfg", `SRF_CFG_RESET, rd);
        apb(1'b0, `SRF_LAT_OFS, 0);
        chk("lat", `SRF_LAT_RESET, rd);
        apb(1'b1, `SRF_STAT_OFS, 32'hFFFF_FFFF);
        chk("stat write error", 1, err);
        apb(1'b0, `SRF_STAT_OFS, 0);
        chk("stat", 32'h0000_000C, rd);
        apb(1'b0, 8'h0C, 0);
        chk("unmapped error", 1, err);
        chk("unmapped data", 0, rd);
        $display("test reset done");
    endtask
    // Refresh with clock enable high; rows come from the internal counter.
    task automatic t_refresh();
        int n;
        ctl.send(4'h1, 1'b1, 1'b0, `SRF_RFC_CYC + 2);
        n = 0;
        #1;
        repeat (`SRF_RFC_CYC + 2) begin
            n += int'(refresh_active);
            tick(1);
        end
        exp_row++;
        chk("refresh length", `SRF_RFC_CYC, n);
        chk("refresh_row", exp_row, refresh_row);
        $display("test refresh done");
    endtask
    // Self-refresh entry, internal refresh, ignored commands and exit.
    task automatic t_self();
        ctl.send(4'h1, 1'b0, 1'b0, 40);
        tick(1);
        chk("loop off", 0, dll_enabled);
        tick(1);
        chk("self active", 1, self_refresh_active);
        chk("internal refresh", 1, refresh_active);
        tick(25);
        exp_row++;
        chk("self row", exp_row, refresh_row);
        ctl.send(4'h4, 1'b0, 1'b0, 0);
        tick(6);
        chk("still in self", 1, self_refresh_active);
        chk("no write beat", 0, wr_first_beat);
        ctl.send(4'h7, 1'b1, 1'b0, `SRF_XS_CYC + 1);
        #1;
        chk("loop reset", 1, dll_reset);
        chk("loop on", 1, dll_enabled);
        chk("self left", 0, self_refresh_active);
        tick(1);
        chk("loop reset pulse", 0, dll_reset);
        $display("test self done");
    endtask
    // Self-refresh with the loop disabled: it stays off and gets no reset pulse on exit.
    task automatic t_self_off();
        apb(1'b1, `SRF_CFG_OFS, 32'h0000_0004);
        tick(1);
        chk("loop off idle", 0, dll_enabled);
        ctl.send(4'h1, 1'b0, 1'b0, 40);
        tick(2);
        chk("self active off", 1, self_refresh_active);
        ctl.send(4'h7, 1'b1, 1'b0, `SRF_XS_CYC + 1);
        #1;
        chk("no loop reset", 0, dll_reset);
        chk("loop stays off", 0, dll_enabled);
        exp_row++;
        chk("self row off", exp_row, refresh_row);
        apb(1'b1, `SRF_CFG_OFS, 32'h0000_0000);
        $display("test self off done");
    endtask
    // Every burst mode and select bit, at two write latencies.
    task automatic t_writes();
        logic [1:0] md [6] = '{2'h2, 2'h0, 2'h1, 2'h3, 2'h1, 2'h1};
        logic [5:0] sel = 6'b100001;
        logic [5:0] e8 = 6'b101010;
        int wl;
        int k;
        wl = 5;
        for (int i = 0; i < 6; i++) begin
            if (i == 3) begin
                apb(1'b1, `SRF_LAT_OFS, 32'h0000_0052);
                wl = 7;
            end
            apb(1'b1, `SRF_CFG_OFS, {30'h0, md[i]});
            ctl.send(4'h4, 1'b1, sel[i], 1);
            k = 0;
            do begin
                tick(1);
                k++;
            end while (wr_first_beat !== 1'b1 && k < 20);
            chk("write latency", wl, k);
            chk("burst_eight", e8[i], burst_eight);
            tick(1);
            chk("beat pulse", 0, wr_first_beat);
        end
        $display("test writes done");
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Main sequence: reset for ten cycles, then each test in turn.
    initial begin
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        exp_row = 16'h0000;
        repeat (10) @(posedge core_clk);
        srst <= 1'b0;
        tick(1);
        t_reset();
        t_refresh();
        t_refresh();
        t_self();
        t_refresh();
        t_self_off();
        t_refresh();
        t_writes();
        print_verdict();
    end
endmodule // sdram_refresh_selfrefresh_write_bench
